// file: inc/pcat_pkg.sv
// Shared constants and types of the counter array time base.
// Assumes a single 100 MHz system clock, which also stands for the
// oscillator frequency that the count source divides.
package pcat_pkg;

    // ------------------------------------------------------------------
    // Clock and count source divisions
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ    = 100_000_000;
    localparam logic [3:0]  DIV_SLOW_STD  = 4'hc;
    localparam logic [3:0]  DIV_SLOW_DBL  = 4'h6;
    localparam logic [3:0]  DIV_FAST_STD  = 4'h4;
    localparam logic [3:0]  DIV_FAST_DBL  = 4'h2;
    localparam logic [3:0]  PRESC_RST     = 4'h0;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_CTRL      = 8'hd8;
    localparam logic [7:0]  IDX_MODE      = 8'hd9;
    localparam logic [7:0]  IDX_MCFG0     = 8'hda;
    localparam logic [7:0]  IDX_IRQ_STAT  = 8'he0;
    localparam logic [7:0]  IDX_IRQ_CLR   = 8'he1;
    localparam logic [7:0]  IDX_IRQ_EN    = 8'he2;
    localparam logic [7:0]  IDX_CNT_LO    = 8'he9;
    localparam logic [7:0]  IDX_CAP_LO0   = 8'hea;
    localparam logic [7:0]  IDX_CNT_HI    = 8'hf9;
    localparam logic [7:0]  IDX_CAP_HI0   = 8'hfa;

    // ------------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_RUN_BIT  = 6;
    localparam logic [7:0]  MODE_IMPL     = 8'hc7;
    localparam logic [7:0]  MODE_RST      = 8'h00;
    localparam logic [3:0]  MCFG_RST      = 4'h0;
    localparam logic [15:0] CNT_RST       = 16'h0000;
    localparam logic [15:0] CNT_TOP       = 16'hffff;
    localparam logic [5:0]  IRQ_RST       = 6'h00;
    localparam int unsigned N_MOD         = 5;
    localparam int unsigned WDT_MOD       = 4;

    typedef enum logic [1:0] {
        SRC_OSC_SLOW = 2'h0,
        SRC_OSC_FAST = 2'h1,
        SRC_T0_OVF   = 2'h2,
        SRC_EXT_PIN  = 2'h3
    } pcat_src_t;

    typedef enum logic [2:0] {
        MM_OFF      = 3'h0,
        MM_CAP_RISE = 3'h1,
        MM_CAP_FALL = 3'h2,
        MM_CAP_BOTH = 3'h3,
        MM_SW_TIMER = 3'h4,
        MM_HS_OUT   = 3'h5,
        MM_PWM      = 3'h6
    } pcat_mmode_t;

    // Same bit layout as the mode register byte
    typedef struct packed {
        logic        idle_stop_bit;
        logic        module4_watchdog_enable;
        logic [2:0]  unused;
        pcat_src_t   count_source_sel;
        logic        overflow_irq_enable;
    } pcat_mode_t;

    typedef struct packed {
        logic        irq_en;
        pcat_mmode_t mode;
    } pcat_mcfg_t;

endpackage

// file: logic/pcat_ccm.sv
// One capture/compare module working off the shared counter.
// Assumes cnt is the shared counter and cnt_step pulses for one cycle
// in the cycle after the counter has advanced.
`timescale 1ns/1ps

module pcat_ccm
    import pcat_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire pcat_mcfg_t  cfg,
    input  wire logic        wdt_allow,
    input  wire logic [15:0] cnt,
    input  wire logic        cnt_step,
    input  wire logic        pin_in,
    input  wire logic        cap_we_lo,
    input  wire logic        cap_we_hi,
    input  wire logic [7:0]  wdata,
    output logic      [15:0] cap_value,
    output logic             event_o,
    output logic             pin_out,
    output logic             pin_oe,
    output logic             wdt_fire
);

    // ------------------------------------------------------------------
    // Pin synchroniser and edge detect
    // ------------------------------------------------------------------
    logic        s1_q, s2_q, prev_q;
    logic [15:0] cap_q, cap_d;
    logic        evt_q, evt_d, out_q, out_d, oe_q, oe_d, wdt_q, wdt_d;
    logic        rise, fall, cap_hit, match;

    assign rise  = s2_q & ~prev_q;
    assign fall  = ~s2_q & prev_q;
    assign match = cnt_step && (cnt == cap_q);

    always_comb begin
        cap_hit = 1'b0;
        case (cfg.mode)
            MM_CAP_RISE: cap_hit = rise;
            MM_CAP_FALL: cap_hit = fall;
            MM_CAP_BOTH: cap_hit = rise | fall;
            default:     cap_hit = 1'b0;
        endcase
    end

    always_comb begin
        cap_d = cap_q;
        evt_d = 1'b0;
        out_d = out_q;
        oe_d  = 1'b0;
        wdt_d = 1'b0;
        if (cap_we_lo) begin
            cap_d[7:0] = wdata;
        end
        if (cap_we_hi) begin
            cap_d[15:8] = wdata;
        end
        case (cfg.mode)
            MM_CAP_RISE, MM_CAP_FALL, MM_CAP_BOTH: begin
                if (cap_hit) begin
                    cap_d = cnt;
                    evt_d = 1'b1;
                end
            end
            MM_SW_TIMER: begin
                evt_d = match;
                wdt_d = match & wdt_allow;
            end
            MM_HS_OUT: begin
                oe_d  = 1'b1;
                evt_d = match;
                if (match) begin
                    out_d = ~out_q;
                end
            end
            MM_PWM: begin
                // Duty follows the low byte only, an 8-bit modulator
                oe_d  = 1'b1;
                out_d = (cnt[7:0] >= cap_q[7:0]);
            end
            default: begin
                out_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // Pins idle high on pull-ups; avoids a false edge after reset
            s1_q   <= 1'b1;
            s2_q   <= 1'b1;
            prev_q <= 1'b1;
            cap_q  <= CNT_RST;
            evt_q  <= 1'b0;
            out_q  <= 1'b0;
            oe_q   <= 1'b0;
            wdt_q  <= 1'b0;
        end else begin
            s1_q   <= pin_in;
            s2_q   <= s1_q;
            prev_q <= s2_q;
            cap_q  <= cap_d;
            evt_q  <= evt_d;
            out_q  <= out_d;
            oe_q   <= oe_d;
            wdt_q  <= wdt_d;
        end
    end

    assign cap_value = cap_q;
    assign event_o   = evt_q;
    assign pin_out   = out_q;
    assign pin_oe    = oe_q;
    assign wdt_fire  = wdt_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_wdt_on_match: assert property (
        (cfg.mode == MM_SW_TIMER && wdt_allow && match) |=> wdt_fire)
        else $error("Watchdog did not fire on compare match");

    chk_capture_event: assert property (
        (cap_hit && !cap_we_lo && !cap_we_hi)
        |=> (event_o && cap_value == $past(cnt)))
        else $error("Capture did not latch counter or raise event");

endmodule

// file: logic/pcat_timebase.sv
// Time base, mode register and shared interrupt of the counter array.
// Assumes a classic Wishbone master, a timer 0 overflow pulse and idle
// and double speed levels from logic on sys_clk; pins are asynchronous.
`timescale 1ns/1ps

module pcat_timebase
    import pcat_pkg::*;
#(
    parameter int unsigned ADR_W = 12
)(
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             double_speed_mode,
    input  wire logic             idle_mode,
    input  wire logic             timer0_ovf,
    input  wire logic             external_count_in,
    input  wire logic [4:0]       mod_io_in,
    output logic      [4:0]       mod_io_out,
    output logic      [4:0]       mod_io_oe,
    output logic                  irq_o,
    output logic                  wdt_reset_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_idx(input logic [ADR_W-1:0] adr,
                                    input logic [7:0]       idx);
        return adr == {{(ADR_W-10){1'b0}}, idx, 2'b00};
    endfunction

    function automatic logic [3:0] div_limit(input pcat_src_t src,
                                             input logic      dbl);
        logic [3:0] div;
        div = 4'h1;
        case (src)
            SRC_OSC_SLOW: div = dbl ? DIV_SLOW_DBL : DIV_SLOW_STD;
            SRC_OSC_FAST: div = dbl ? DIV_FAST_DBL : DIV_FAST_STD;
            default:      div = 4'h1;
        endcase
        return div - 4'h1;
    endfunction

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WB_IDLE = 2'b01,
        WB_ACK  = 2'b10
    } pcat_wb_st_t;

    pcat_wb_st_t st_q, st_d;
    logic        ack_q, ack_d;
    logic [7:0]  rdat_q, rdat_d, rd_mux;
    logic        wr, req;
    logic [7:0]  wd;

    pcat_mode_t  mode_q, mode_d;
    logic        run_q, run_d;
    pcat_mcfg_t  mcfg_q [N_MOD];
    pcat_mcfg_t  mcfg_d [N_MOD];
    logic [5:0]  stat_q, stat_d, en_q, en_d, eff_en, set_v, clr_v;
    logic        irq_q, irq_d, wdt_q, wdt_d;
    logic [15:0] cap_val [N_MOD];
    logic [15:0] cnt_q, cnt_d;
    logic [4:0]  mod_evt, mod_wdt, mod_ie;

    assign req = wb_cyc_i & wb_stb_i;
    // Write lands on the edge at which the master samples ack
    assign wr  = req & wb_we_i & wb_sel_i[0] & ack_q;
    assign wd  = wb_dat_i[7:0];

    always_comb begin
        rd_mux = 8'h00;
        if (is_idx(wb_adr_i, IDX_CTRL)) begin
            rd_mux[CTRL_RUN_BIT] = run_q;
        end else if (is_idx(wb_adr_i, IDX_MODE)) begin
            // Unimplemented bits read back as zero
            rd_mux = mode_q & MODE_IMPL;
        end else if (is_idx(wb_adr_i, IDX_IRQ_STAT)) begin
            rd_mux = {2'h0, stat_q};
        end else if (is_idx(wb_adr_i, IDX_IRQ_EN)) begin
            rd_mux = {2'h0, en_q};
        end else if (is_idx(wb_adr_i, IDX_CNT_LO)) begin
            rd_mux = cnt_q[7:0];
        end else if (is_idx(wb_adr_i, IDX_CNT_HI)) begin
            rd_mux = cnt_q[15:8];
        end
        for (int k = 0; k < N_MOD; k++) begin
            if (is_idx(wb_adr_i, IDX_MCFG0 + 8'(k))) begin
                rd_mux = {4'h0, mcfg_q[k]};
            end
            if (is_idx(wb_adr_i, IDX_CAP_LO0 + 8'(k))) begin
                rd_mux = cap_val[k][7:0];
            end
            if (is_idx(wb_adr_i, IDX_CAP_HI0 + 8'(k))) begin
                rd_mux = cap_val[k][15:8];
            end
        end
    end

    always_comb begin
        st_d   = st_q;
        ack_d  = 1'b0;
        rdat_d = rdat_q;
        case (st_q)
            WB_IDLE: begin
                if (req) begin
                    ack_d  = 1'b1;
                    rdat_d = rd_mux;
                    st_d   = WB_ACK;
                end
            end
            WB_ACK: begin
                st_d = WB_IDLE;
            end
            default: begin
                st_d = WB_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q   <= WB_IDLE;
            ack_q  <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            st_q   <= st_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = {24'h000000, rdat_q};

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        run_d  = run_q;
        en_d   = en_q;
        for (int k = 0; k < N_MOD; k++) begin
            mcfg_d[k] = mcfg_q[k];
            if (wr && is_idx(wb_adr_i, IDX_MCFG0 + 8'(k))) begin
                mcfg_d[k] = wd[3:0];
            end
        end
        if (wr && is_idx(wb_adr_i, IDX_MODE)) begin
            mode_d = wd & MODE_IMPL;
        end
        if (wr && is_idx(wb_adr_i, IDX_CTRL)) begin
            run_d = wd[CTRL_RUN_BIT];
        end
        if (wr && is_idx(wb_adr_i, IDX_IRQ_EN)) begin
            en_d = wd[5:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_RST;
            run_q  <= 1'b0;
            en_q   <= IRQ_RST;
            for (int k = 0; k < N_MOD; k++) begin
                mcfg_q[k] <= MCFG_RST;
            end
        end else begin
            mode_q <= mode_d;
            run_q  <= run_d;
            en_q   <= en_d;
            for (int k = 0; k < N_MOD; k++) begin
                mcfg_q[k] <= mcfg_d[k];
            end
        end
    end

    // ------------------------------------------------------------------
    // Count source and shared counter
    // ------------------------------------------------------------------
    logic [3:0]  presc_q, presc_d, lim;
    logic        ext_s1_q, ext_s2_q, ext_prev_q, ext_fall;
    logic        src_tick, adv, ovf, step_q, cnt_wr;

    assign lim      = div_limit(mode_q.count_source_sel, double_speed_mode);
    assign ext_fall = ext_prev_q & ~ext_s2_q;

    always_comb begin
        presc_d  = (presc_q >= lim) ? PRESC_RST : presc_q + 4'h1;
        src_tick = 1'b0;
        case (mode_q.count_source_sel)
            SRC_OSC_SLOW: src_tick = (presc_q == lim);
            SRC_OSC_FAST: src_tick = (presc_q == lim);
            SRC_T0_OVF:   src_tick = timer0_ovf;
            SRC_EXT_PIN:  src_tick = ext_fall;
            default:      src_tick = 1'b0;
        endcase
    end

    // Idle only halts when the stop bit asks for it
    assign adv    = run_q & src_tick &
                    ~(idle_mode & mode_q.idle_stop_bit);
    assign ovf    = adv & (cnt_q == CNT_TOP);
    assign cnt_wr = wr & (is_idx(wb_adr_i, IDX_CNT_LO) |
                          is_idx(wb_adr_i, IDX_CNT_HI));

    always_comb begin
        cnt_d = adv ? cnt_q + 16'h0001 : cnt_q;
        if (wr && is_idx(wb_adr_i, IDX_CNT_LO)) begin
            cnt_d[7:0] = wd;
        end
        if (wr && is_idx(wb_adr_i, IDX_CNT_HI)) begin
            cnt_d[15:8] = wd;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            presc_q    <= PRESC_RST;
            ext_s1_q   <= 1'b1;
            ext_s2_q   <= 1'b1;
            ext_prev_q <= 1'b1;
            cnt_q      <= CNT_RST;
            step_q     <= 1'b0;
        end else begin
            presc_q    <= presc_d;
            ext_s1_q   <= external_count_in;
            ext_s2_q   <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
            cnt_q      <= cnt_d;
            step_q     <= adv;
        end
    end

    // ------------------------------------------------------------------
    // Capture/compare modules
    // ------------------------------------------------------------------
    for (genvar g = 0; g < N_MOD; g++) begin : g_mod
        pcat_ccm u_ccm (
            .sys_clk   (sys_clk),
            .rstn      (rstn),
            .cfg       (mcfg_q[g]),
            .wdt_allow ((g == WDT_MOD) &&
                        mode_q.module4_watchdog_enable),
            .cnt       (cnt_q),
            .cnt_step  (step_q),
            .pin_in    (mod_io_in[g]),
            .cap_we_lo (wr && is_idx(wb_adr_i, IDX_CAP_LO0 + 8'(g))),
            .cap_we_hi (wr && is_idx(wb_adr_i, IDX_CAP_HI0 + 8'(g))),
            .wdata     (wd),
            .cap_value (cap_val[g]),
            .event_o   (mod_evt[g]),
            .pin_out   (mod_io_out[g]),
            .pin_oe    (mod_io_oe[g]),
            .wdt_fire  (mod_wdt[g])
        );
        assign mod_ie[g] = mcfg_q[g].irq_en;
    end

    // ------------------------------------------------------------------
    // Shared interrupt and watchdog reset
    // ------------------------------------------------------------------
    assign set_v  = {mod_evt, ovf};
    assign clr_v  = (wr && is_idx(wb_adr_i, IDX_IRQ_CLR)) ? wd[5:0] : 6'h00;
    assign eff_en = en_q & {mod_ie, mode_q.overflow_irq_enable};

    always_comb begin
        // Set wins over a clear in the same cycle
        stat_d = (stat_q & ~clr_v) | set_v;
        irq_d  = |(stat_q & eff_en);
        wdt_d  = mod_wdt[WDT_MOD];
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stat_q <= IRQ_RST;
            irq_q  <= 1'b0;
            wdt_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q  <= irq_d;
            wdt_q  <= wdt_d;
        end
    end

    assign irq_o       = irq_q;
    assign wdt_reset_o = wdt_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_wrap;
        adv && !cnt_wr && (cnt_q == CNT_TOP);
    endsequence

    chk_slow_div: assert property (
        (mode_q.count_source_sel == SRC_OSC_SLOW && src_tick)
        |-> presc_q == (double_speed_mode ? 4'h5 : 4'hb))
        else $error("Slow oscillator division wrong");

    chk_fast_div: assert property (
        (mode_q.count_source_sel == SRC_OSC_FAST && src_tick)
        |-> presc_q == (double_speed_mode ? 4'h1 : 4'h3))
        else $error("Fast oscillator division wrong");

    chk_t0_count: assert property (
        (mode_q.count_source_sel == SRC_T0_OVF && run_q && timer0_ovf
         && !idle_mode && !cnt_wr) |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("Timer 0 overflow not counted");

    chk_ext_count: assert property (
        (mode_q.count_source_sel == SRC_EXT_PIN && run_q && ext_fall
         && !idle_mode && !cnt_wr) |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("External count edge not counted");

    chk_idle_halt: assert property (
        (idle_mode && mode_q.idle_stop_bit && !cnt_wr) |=> $stable(cnt_q))
        else $error("Counter moved while halted in idle");

    chk_ovf_flag: assert property (
        s_wrap |=> (stat_q[0] && cnt_q == CNT_RST))
        else $error("Overflow did not wrap and flag");

    chk_irq_merge: assert property (
        ##1 irq_o == |($past(stat_q) & $past(eff_en)))
        else $error("Shared interrupt does not follow status");

    chk_ovf_gate: assert property (
        (!mode_q.overflow_irq_enable && stat_q[5:1] == 5'h0)
        ##1 (!mode_q.overflow_irq_enable) |-> !irq_o)
        else $error("Overflow requested interrupt while disabled");

    chk_wdt_gate: assert property (
        !mode_q.module4_watchdog_enable [*3] |-> !wdt_reset_o)
        else $error("Watchdog reset while watchdog disabled");

    chk_bus_ack: assert property (
        (req && st_q == WB_IDLE) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus ack not a single cycle pulse");

endmodule

// file: tb/pcat_pin_model.sv
// Far side model: external count source and module pins of port 1.
// Assumes the design samples these pins through its own synchronizers.
`timescale 1ns/1ps

module pcat_pin_model (
    input  wire logic       sys_clk,
    input  wire logic [4:0] pin_out,
    input  wire logic [4:0] pin_oe,
    output logic            ext_cnt,
    output logic      [4:0] pin_in
);
    logic [4:0] drv;

    // Pull-ups hold released lines high
    initial begin
        ext_cnt = 1'b1;
        drv = 5'h1f;
    end

    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);

    // Four low, four high: a quarter of the fastest rate the count input allows, which counts one low, one high
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge sys_clk);
            ext_cnt <= 1'b0;
            repeat (4) @(posedge sys_clk);
            ext_cnt <= 1'b1;
        end
    endtask

    task automatic set_pin(input int i, input logic v);
        @(posedge sys_clk);
        drv[i] <= v;
    endtask
endmodule

// file: tb/pcat_timebase_tb_top.sv
// Bench for the counter array time base: bus tasks and directed checks.
// Assumes the pin model on the far side and a 100 MHz sys_clk.
`timescale 1ns/1ps

module pcat_timebase_tb_top;
    import pcat_pkg::*;
    logic        sys_clk, rstn, cyc, stb, we, dbl, idle, t0, ack, irq;
    logic        wdt, ext;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [4:0]  pin_in, pin_out, pin_oe;
    logic [7:0]  a, b;
    int          failures, checked, wdt_n;

    pcat_timebase pcat_timebase_i (
        .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .double_speed_mode(dbl),
        .idle_mode(idle), .timer0_ovf(t0), .external_count_in(ext),
        .mod_io_in(pin_in), .mod_io_out(pin_out), .mod_io_oe(pin_oe),
        .irq_o(irq), .wdt_reset_o(wdt));

    pcat_pin_model pcat_pin_model_i (
        .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_cnt(ext), .pin_in(pin_in));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (wdt === 1'b1) wdt_n++;
    end

    task automatic stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {2'h0, idx, 2'h0};
        wdat <= {24'h0, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (ack !== 1'b1) begin
            failures++;
            $display("ERROR bus ack expected 1 seen %b", ack);
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] q);
        bus(1'b0, idx, 8'h00, q);
    endtask

    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", nm, e, s);
        end
    endtask

    // Reads exactly 120 cycles apart, a whole number of prescaler periods
    task automatic rate(input logic [7:0] m, input logic d,
                        input logic [7:0] e, input string nm);
        dbl <= d;
        wr(IDX_MODE, m);
        repeat (20) @(posedge sys_clk);
        rd(IDX_CNT_LO, a);
        repeat (117) @(posedge sys_clk);
        rd(IDX_CNT_LO, b);
        chk8(nm, e, b - a);
    endtask

    task automatic ovf(input logic [7:0] m);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CNT_LO, 8'hff);
        wr(IDX_CNT_HI, 8'hff);
        wr(IDX_MODE, m);
        wr(IDX_CTRL, 8'h40);
        repeat (10) @(posedge sys_clk);
        wr(IDX_CTRL, 8'h00);
        rd(IDX_IRQ_STAT, a);
        chk8("overflow flag", 8'h01, a);
    endtask

    task automatic wd(input logic [7:0] m, input logic [7:0] e);
        wr(IDX_CNT_LO, 8'h00);
        wr(IDX_CNT_HI, 8'h00);
        wr(IDX_MODE, m);
        wdt_n = 0;
        wr(IDX_CTRL, 8'h40);
        repeat (60) @(posedge sys_clk);
        wr(IDX_CTRL, 8'h00);
        chk8("watchdog pulses", e, 8'(wdt_n));
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("ERROR watchdog expected finish seen timeout");
        stop_test();
    end

    initial begin
        {rstn, cyc, stb, we, dbl, idle, t0} = '0;
        adr = '0;
        sel = '0;
        wdat = '0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(IDX_MODE, a);
        chk8("mode reset", MODE_RST, a);
        chk1("irq reset", 1'b0, irq);
        wr(IDX_MODE, 8'hc7);
        rd(IDX_MODE, a);
        chk8("mode rw", 8'hc7, a);
        rd(8'hff, a);
        chk8("unmapped", 8'h00, a);
        rd(IDX_IRQ_CLR, a);
        chk8("clear reads", 8'h00, a);
        wr(IDX_CTRL, 8'h40);
        rate(8'h00, 1'b0, 8'd10, "div 12");
        rate(8'h00, 1'b1, 8'd20, "div 6");
        rate(8'h02, 1'b0, 8'd30, "div 4");
        rate(8'h02, 1'b1, 8'd60, "div 2");
        idle <= 1'b1;
        rate(8'h80, 1'b0, 8'd0, "idle halt");
        rate(8'h00, 1'b0, 8'd10, "idle run");
        idle <= 1'b0;
        wr(IDX_MODE, 8'h04);
        rd(IDX_CNT_LO, a);
        repeat (5) begin
            @(posedge sys_clk) t0 <= 1'b1;
            @(posedge sys_clk) t0 <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        rd(IDX_CNT_LO, b);
        chk8("timer0 count", 8'd5, b - a);
        wr(IDX_MODE, 8'h06);
        rd(IDX_CNT_LO, a);
        pcat_pin_model_i.pulses(6);
        repeat (8) @(posedge sys_clk);
        rd(IDX_CNT_LO, b);
        chk8("external count", 8'd6, b - a);
        wr(IDX_IRQ_EN, 8'h01);
        ovf(8'h03);
        chk1("overflow irq", 1'b1, irq);
        wr(IDX_IRQ_CLR, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk1("irq cleared", 1'b0, irq);
        ovf(8'h02);
        chk1("overflow gated", 1'b0, irq);
        wr(IDX_IRQ_CLR, 8'h01);
        for (int m = 0; m < 7; m++) begin
            wr(IDX_MCFG0, 8'(m));
            repeat (2) @(posedge sys_clk);
            chk1("pin drive", m == 5 || m == 6, pin_oe[0]);
            chk1("pin level", m == 6, pin_out[0]);
        end
        wr(IDX_MCFG0, 8'h00);
        wr(IDX_CNT_LO, 8'h5a);
        wr(IDX_IRQ_EN, 8'h04);
        wr(IDX_MCFG0 + 8'h01, 8'h09);
        pcat_pin_model_i.set_pin(1, 1'b0);
        repeat (6) @(posedge sys_clk);
        pcat_pin_model_i.set_pin(1, 1'b1);
        repeat (8) @(posedge sys_clk);
        rd(IDX_IRQ_STAT, a);
        chk8("capture flag", 8'h04, a);
        chk1("capture irq", 1'b1, irq);
        rd(IDX_CAP_LO0 + 8'h01, a);
        chk8("capture value", 8'h5a, a);
        wr(IDX_IRQ_CLR, 8'h04);
        wr(IDX_CAP_LO0 + 8'h04, 8'h08);
        wr(IDX_MCFG0 + 8'h04, 8'h04);
        wd(8'h42, 8'd1);
        wd(8'h02, 8'd0);
        stop_test();
    end
endmodule
